// ---- core/pa_control_defs.vh ----
`ifndef PA_CONTROL_DEFS_VH
`define PA_CONTROL_DEFS_VH

// Register indexes, byte address is four times the index
`define IDX_STATUS 6'h01
`define IDX_CFG0 6'h04
`define IDX_CFG1 6'h05
`define IDX_SLOPE 6'h19
`define IDX_BLOCKS 6'h1a
`define IDX_COUNT 6'h1b
`define IDX_TUNE 6'h1f
`define IDX_CMD 6'h20
`define IDX_BAND 6'h21

// Field positions
`define CFG0_FS_OFF 4
`define CFG1_SLOPE_EN 4
`define CFG1_MOD_ONE 5
`define CFG1_MOD_TWO 6
`define CMD_START 0
`define CMD_SETUP 1
`define CMD_STOP 2
`define TUNE_DUTY_DIS 6

// Reset values
`define RST_CFG0 8'h06
`define RST_CFG1 8'h25
`define RST_SLOPE 8'h80
`define RST_BLOCKS 8'h00
`define RST_COUNT 8'h00
`define RST_TUNE 8'h00

// Duty figures in percent
`define DUTY_FULL 6'h32
`define DUTY_BAND 6'h21
`define DUTY_C0 6'h1f
`define DUTY_C1 6'h23
`define DUTY_C2 6'h27
`define DUTY_C3 6'h2b

`define STAGES 11

`endif

// ---- core/pa_stage_power_control.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pa_control_defs.vh"

module pa_stage_power_control (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Transmit data and error events
	input wire tx_data,
	input wire parity_error,
	input wire undervoltage_detector,
	input wire pll_lock_monitor,
	// Amplifier controls
	output reg [10:0] stage_enable,
	output reg [2:0] block_enable,
	output reg [5:0] duty_percent,
	output reg [3:0] antenna_tuning_switches,
	output reg tx_active,
	output reg amplifier_off
);

// ==========================================
// Functions
function [3:0] block_limit;
	input [2:0] sel;
	begin
		if (sel[2])
			block_limit = 4'd11;
		else if (sel[1])
			block_limit = 4'd10;
		else if (sel[0])
			block_limit = 4'd9;
		else
			block_limit = 4'd0;
	end
endfunction

function [10:0] thermometer;
	input [3:0] n;
	integer i;
	begin
		thermometer = 11'h000;
		for (i = 0; i < `STAGES; i = i + 1) begin
			if (i < n)
				thermometer[i] = 1'b1;
		end
	end
endfunction

function [2:0] blocks_of;
	input [3:0] n;
	begin
		blocks_of = {n > 4'd10, n > 4'd9, n != 4'd0};
	end
endfunction

function is_mapped;
	input [5:0] a;
	begin
		case (a)
			`IDX_STATUS: is_mapped = 1'b1;
			`IDX_CFG0: is_mapped = 1'b1;
			`IDX_CFG1: is_mapped = 1'b1;
			`IDX_SLOPE: is_mapped = 1'b1;
			`IDX_BLOCKS: is_mapped = 1'b1;
			`IDX_COUNT: is_mapped = 1'b1;
			`IDX_TUNE: is_mapped = 1'b1;
			`IDX_CMD: is_mapped = 1'b1;
			`IDX_BAND: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	end
endfunction

function [5:0] duty_of;
	input [1:0] code;
	begin
		case (code)
			2'd0: duty_of = `DUTY_C0;
			2'd1: duty_of = `DUTY_C1;
			2'd2: duty_of = `DUTY_C2;
			2'd3: duty_of = `DUTY_C3;
			default: duty_of = `DUTY_FULL;
		endcase
	end
endfunction

function [3:0] step_toward;
	input [3:0] cur;
	input [3:0] tgt;
	begin
		if (cur < tgt)
			step_toward = cur + 4'd1;
		else if (cur > tgt)
			step_toward = cur - 4'd1;
		else
			step_toward = cur;
	end
endfunction

// ==========================================
// Registers
reg [7:0] cfg0;
reg [7:0] cfg1;
reg [7:0] slope_div;
reg [7:0] blocks;
reg [7:0] counts;
reg [7:0] tune;
reg band_315;
reg setup_two;
reg [2:0] err_flags;
reg tripped;
reg [3:0] cur_count;
reg [9:0] div_cnt;

wire acc = psel & penable & ~pready;
wire done = psel & penable & pready;
wire [5:0] idx = paddr[7:2];
wire wr = done & pwrite;
wire rd_status = done & ~pwrite & (idx == `IDX_STATUS);
wire mapped = is_mapped(idx);
wire start = wr & (idx == `IDX_CMD) & pwdata[`CMD_START];
wire stop = wr & (idx == `IDX_CMD) & pwdata[`CMD_STOP];
wire wr_cfg0 = wr & (idx == `IDX_CFG0);
wire wr_cfg1 = wr & (idx == `IDX_CFG1);
wire wr_slope = wr & (idx == `IDX_SLOPE);
wire wr_blocks = wr & (idx == `IDX_BLOCKS);
wire wr_count = wr & (idx == `IDX_COUNT);
wire wr_tune = wr & (idx == `IDX_TUNE);
wire wr_band = wr & (idx == `IDX_BAND);
wire armed = ~cfg0[`CFG0_FS_OFF];
wire [2:0] events = {pll_lock_monitor, undervoltage_detector, parity_error};
wire any_err = |events;

// ==========================================
// Bus access
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		pready <= 1'b0;
	else
		pready <= acc;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		pslverr <= 1'b0;
	else if (acc)
		pslverr <= ~mapped;
	else
		pslverr <= 1'b0;
end

// Flags are read with this cycle's events, so the read clear never loses one
reg [31:0] next_prdata;
always @* begin
	case (idx)
		`IDX_STATUS: next_prdata = {27'h0, tripped, 1'b0, err_flags | events};
		`IDX_CFG0: next_prdata = {24'h000000, cfg0};
		`IDX_CFG1: next_prdata = {24'h000000, cfg1};
		`IDX_SLOPE: next_prdata = {24'h000000, slope_div};
		`IDX_BLOCKS: next_prdata = {24'h000000, blocks};
		`IDX_COUNT: next_prdata = {24'h000000, counts};
		`IDX_TUNE: next_prdata = {24'h000000, tune};
		`IDX_CMD: next_prdata = {30'h0, setup_two, tx_active};
		`IDX_BAND: next_prdata = {31'h0, band_315};
		default: next_prdata = 32'h00000000;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		prdata <= 32'h00000000;
	else if (acc)
		prdata <= next_prdata;
end

// ==========================================
// Register file
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		cfg0 <= `RST_CFG0;
	else if (wr_cfg0)
		cfg0 <= pwdata[7:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		cfg1 <= `RST_CFG1;
	else if (wr_cfg1)
		cfg1 <= pwdata[7:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		slope_div <= `RST_SLOPE;
	else if (wr_slope)
		slope_div <= pwdata[7:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		blocks <= `RST_BLOCKS;
	else if (wr_blocks)
		blocks <= pwdata[7:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		counts <= `RST_COUNT;
	else if (wr_count)
		counts <= pwdata[7:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		tune <= `RST_TUNE;
	else if (wr_tune)
		tune <= pwdata[7:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		band_315 <= 1'b0;
	else if (wr_band)
		band_315 <= pwdata[0];
end

// ==========================================
// Transmission and fail-safe
wire trip = armed & tx_active & any_err;

// Flags set on each error whether armed or not; set beats read clear
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		err_flags <= 3'h0;
	else
		err_flags <= (rd_status ? 3'h0 : err_flags) | events;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		tx_active <= 1'b0;
	else if (trip)
		tx_active <= 1'b0;
	else if (start)
		tx_active <= 1'b1;
	else if (stop)
		tx_active <= 1'b0;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		setup_two <= 1'b0;
	else if (start)
		setup_two <= pwdata[`CMD_SETUP];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		tripped <= 1'b0;
	else if (!armed)
		tripped <= 1'b0;
	else if (trip)
		tripped <= 1'b1;
	else if (start)
		tripped <= 1'b0;
end

// ==========================================
// Stage target
wire [2:0] level_one_block_select = blocks[4:2];
wire [2:0] level_two_block_select = blocks[7:5];
wire [3:0] level_one_stage_count = counts[3:0];
wire [3:0] level_two_stage_count = counts[7:4];
wire [9:0] sloping_divider_value = {blocks[1:0], slope_div};
wire amplitude_sloping_enable = cfg1[`CFG1_SLOPE_EN];
wire ask_mode = setup_two ? cfg1[`CFG1_MOD_TWO] : cfg1[`CFG1_MOD_ONE];

reg [3:0] level_stage_count;
reg [3:0] limit;
reg [3:0] target;
always @* begin
	if (setup_two) begin
		level_stage_count = level_two_stage_count;
		limit = block_limit(level_two_block_select);
	end else begin
		level_stage_count = level_one_stage_count;
		limit = block_limit(level_one_block_select);
	end
	target = (level_stage_count < limit) ? level_stage_count : limit;
	if (!tx_active | (armed & (tripped | any_err)))
		target = 4'd0;
	else if (ask_mode & ~tx_data)
		target = 4'd0;
end

// ==========================================
// Sloping
wire step_tick = (div_cnt == sloping_divider_value);
wire force_off = armed & (tripped | any_err);
wire slope_hold = force_off | ~amplitude_sloping_enable;

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		div_cnt <= 10'h000;
	else if (slope_hold | (cur_count == target) | step_tick)
		div_cnt <= 10'h000;
	else
		div_cnt <= div_cnt + 10'h001;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		cur_count <= 4'd0;
	else if (slope_hold)
		cur_count <= target;
	else if (step_tick)
		cur_count <= step_toward(cur_count, target);
end

// ==========================================
// Outputs
reg [5:0] next_duty;
always @* begin
	if (band_315)
		next_duty = `DUTY_BAND;
	else if (tune[`TUNE_DUTY_DIS])
		next_duty = `DUTY_FULL;
	else
		next_duty = duty_of(tune[5:4]);
end

wire [3:0] drive = force_off ? 4'd0 : cur_count;

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		stage_enable <= 11'h000;
	else
		stage_enable <= thermometer(drive);
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		block_enable <= 3'h0;
	else
		block_enable <= blocks_of(drive);
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		duty_percent <= `DUTY_FULL;
	else
		duty_percent <= next_duty;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		antenna_tuning_switches <= 4'h0;
	else
		antenna_tuning_switches <= tune[3:0];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		amplifier_off <= 1'b1;
	else
		amplifier_off <= (drive == 4'd0);
end

endmodule // pa_stage_power_control
`default_nettype wire

// ---- verif/pa_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checks
module pa_monitor (
	// Bus
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Amplifier
	input wire [10:0] stage_enable,
	input wire [5:0] duty_percent,
	input wire amplifier_off
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_s; psel && penable && !pready; endsequence
	sequence empty_s; (stage_enable == 11'h000)[*2]; endsequence
	sequence busy_s; (stage_enable != 11'h000)[*2]; endsequence
	ready_after_access_a: assert property (access_s |=> pready)
		else $error("pready late");
	ready_single_a: assert property (pready |=> !pready)
		else $error("pready held");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	refused_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read data");
	stage_order_a: assert property (((stage_enable + 11'h001) & stage_enable) == 11'h000)
		else $error("stages not in order");
	duty_legal_a: assert property (duty_percent inside {6'h32, 6'h21, 6'h1f, 6'h23, 6'h27, 6'h2b})
		else $error("duty value");
	off_when_empty_a: assert property (empty_s |-> amplifier_off)
		else $error("off flag low");
	on_when_busy_a: assert property (busy_s |-> !amplifier_off)
		else $error("off flag high");
endmodule // pa_monitor
bind pa_stage_power_control pa_monitor pa_monitor_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.stage_enable(stage_enable),
	.duty_percent(duty_percent),
	.amplifier_off(amplifier_off)
);
`default_nettype wire

// ---- verif/apb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========
// Host bus master
module apb_host (
	// Bus
	input wire pclk,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata} <= '0;
	end
	// Commands and fail-safe changes travel as plain writes
	task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
			output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // apb_host
`default_nettype wire

// ---- verif/pa_stage_power_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pa_control_defs.vh"
// ========
// Bench
module pa_stage_power_control_tb;
	logic pclk = 1'b0, presetn = 1'b0, tx_data = 1'b0;
	logic parity_error = 1'b0, undervoltage_detector = 1'b0, pll_lock_monitor = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, tx_active, amplifier_off, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [10:0] stage_enable;
	logic [2:0] block_enable;
	logic [5:0] duty_percent;
	logic [3:0] antenna_tuning_switches;
	int n_fail = 0, tests_run = 0;
	pa_stage_power_control pa_stage_power_control_i (.*);
	apb_host apb_host_i (.*);
	always #25 pclk = ~pclk;
	task automatic check(input logic [31:0] s, x);
		tests_run++;
		if (s !== x) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		apb_host_i.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] x);
		apb_host_i.xfer(1'b0, a, 8'h00, q, e);
		check(q, {24'h0, x});
	endtask
	task automatic wn(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic stg(input logic [10:0] x);
		wn(3);
		check(32'(stage_enable), 32'(x));
	endtask
	task automatic t_reset;
		rd(`IDX_CFG0, `RST_CFG0);
		rd(`IDX_CFG1, `RST_CFG1);
		rd(`IDX_SLOPE, `RST_SLOPE);
		rd(`IDX_BLOCKS, 8'h00);
		rd(`IDX_COUNT, 8'h00);
		rd(`IDX_TUNE, 8'h00);
		apb_host_i.xfer(1'b0, 6'h3e, 8'h00, q, e);
		check(32'(e), 32'h1);
		check(32'(amplifier_off), 32'h1);
		$display("reset test over");
	endtask
	task automatic t_duty;
		for (int c = 0; c < 4; c++) begin
			wr(`IDX_TUNE, {2'b00, 2'(c), 4'h1 << c});
			wn(2);
			check(32'(duty_percent), 32'(31 + 4 * c));
			check(32'(antenna_tuning_switches), 32'(4'h1 << c));
		end
		wr(`IDX_TUNE, 8'h70);
		wn(2);
		check(32'(duty_percent), 32'd50);
		wr(`IDX_BAND, 8'h01);
		wn(2);
		check(32'(duty_percent), 32'd33);
		wr(`IDX_BAND, 8'h00);
		$display("duty test over");
	endtask
	task automatic t_levels;
		wr(`IDX_BLOCKS, 8'h30);
		wr(`IDX_COUNT, 8'hbb);
		wr(`IDX_CFG1, 8'h20);
		tx_data <= 1'b1;
		wr(`IDX_CMD, 8'h01);
		stg(11'h7ff);
		check(32'(block_enable), 32'h7);
		tx_data <= 1'b0;
		stg(11'h000);
		wr(`IDX_CMD, 8'h04);
		wr(`IDX_CMD, 8'h03);
		stg(11'h1ff);
		wr(`IDX_CMD, 8'h04);
		wr(`IDX_COUNT, 8'h0b);
		wr(`IDX_CMD, 8'h03);
		stg(11'h000);
		wr(`IDX_CMD, 8'h04);
		$display("level test over");
	endtask
	task automatic t_slope;
		int t1 = -1, t11 = -1;
		wr(`IDX_COUNT, 8'hbb);
		wr(`IDX_SLOPE, 8'h03);
		wr(`IDX_CFG1, 8'h30);
		tx_data <= 1'b1;
		wr(`IDX_CMD, 8'h01);
		for (int i = 0; i < 80; i++) begin
			if (stage_enable === 11'h001 && t1 < 0) t1 = i;
			if (stage_enable === 11'h7ff && t11 < 0) t11 = i;
			wn(1);
		end
		check(32'(t11 - t1), 32'd40);
		wr(`IDX_CMD, 8'h04);
		tx_data <= 1'b0;
		wn(60);
		$display("slope test over");
	endtask
	task automatic t_fail;
		wr(`IDX_CFG1, 8'h20);
		tx_data <= 1'b1;
		wr(`IDX_CMD, 8'h01);
		parity_error <= 1'b1;
		wn(1);
		parity_error <= 1'b0;
		stg(11'h000);
		check(32'(tx_active), 32'h0);
		rd(`IDX_STATUS, 8'h11);
		wr(`IDX_CFG0, 8'h16);
		wr(`IDX_CMD, 8'h01);
		undervoltage_detector <= 1'b1;
		wn(1);
		undervoltage_detector <= 1'b0;
		stg(11'h7ff);
		rd(`IDX_STATUS, 8'h02);
		wr(`IDX_CFG0, 8'h06);
		pll_lock_monitor <= 1'b1;
		wn(1);
		pll_lock_monitor <= 1'b0;
		stg(11'h000);
		rd(`IDX_STATUS, 8'h14);
		$display("fail-safe test over");
	endtask
	task automatic t_rst;
		wr(`IDX_CFG0, 8'h16);
		wr(`IDX_CMD, 8'h01);
		presetn <= 1'b0;
		wn(2);
		check(32'(tx_active), 32'h0);
		check(32'(duty_percent), 32'd50);
		check(32'(amplifier_off), 32'h1);
		presetn <= 1'b1;
		wn(1);
		rd(`IDX_CFG0, `RST_CFG0);
		$display("reset rearm test over");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		wn(20);
		presetn <= 1'b1;
		wn(1);
		t_reset;
		t_duty;
		t_levels;
		t_slope;
		t_fail;
		t_rst;
		test_done;
	end
	initial begin
		wn(20000);
		n_fail++;
		test_done;
	end
endmodule // pa_stage_power_control_tb
`default_nettype wire
